// >>> rtl/hdpsl_pkg.sv
package hdpsl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Link control characters
   localparam logic [7:0] CH_DLE = 8'h10;
   localparam logic [7:0] CH_SOH = 8'h01;
   localparam logic [7:0] CH_STX = 8'h02;
   localparam logic [7:0] CH_ETX = 8'h03;
   localparam logic [7:0] CH_EOT = 8'h04;
   localparam logic [7:0] CH_ENQ = 8'h05;
   localparam logic [7:0] CH_ACK = 8'h06;
   localparam logic [7:0] CH_NAK = 8'h15;
   localparam logic [7:0] BCAST_ADDR = 8'hFF;

   ////////////////////////////////////////////////////////////////////////////
   // Message size limits and header byte positions
   localparam int MSG_MIN = 6;
   localparam int MSG_MAX = 250;
   localparam int HDR_B0 = 1;
   localparam int HDR_B1 = 2;
   localparam int HDR_B2 = 4;
   localparam int HDR_B3 = 5;
   localparam int TXF_DEPTH = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [7:0] SUM_RST = 8'h00;
   localparam logic [7:0] LEN_RST = 8'h00;
   localparam logic [3:0] SENDS_RST = 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [7:0] data;
      logic err;
   } hdpsl_rx_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } hdpsl_byte_t;

   typedef enum logic [4:0] {
      S_IDLE, S_ADDR, S_STX, S_BODY, S_BCC, S_SKIP, S_EAT, S_PADDR, S_PBCC,
      S_EVAL, S_SINK, S_TXC, S_FETCH, S_TXM, S_DRAIN
   } hdpsl_st_t;

endpackage : hdpsl_pkg

// >>> rtl/hdpsl_fifo.sv
module hdpsl_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW:0] wp_q;
   logic [AW:0] rp_q;
   logic push;
   logic pop;

   // Pointers carry one extra bit so full and empty are told apart
   assign in_ready_o = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
   assign out_valid_o = wp_q != rp_q;
   assign out_data_o = mem[rp_q[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Storage has no reset; only the pointers define its contents
   always_ff @(posedge ref_clk_i)
   begin
      if (push)
      begin
         mem[wp_q[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         wp_q <= wp_q + (AW+1)'(push);
         rp_q <= rp_q + (AW+1)'(pop);
      end
   end

   a_fifo_no_overrun : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !in_ready_o |=> $stable(wp_q))
      else $error("fifo written while full");

endmodule : hdpsl_fifo

// >>> rtl/hdpsl_link.sv
// How it works
// - Idle: ignore everything but start-of-message, poll, acknowledge and negative acknowledge pairs.
// - Start-of-message clears block check sum and message buffer.
// - Next data code must be our station number, or 255 if broadcast enabled.
// - Address mismatch: skip to end of packet, then wait again.
// - Matching address enters sum; then require DLE STX, else abandon.
// - Each destuffed body data code is buffered and summed.
// - On buffer overflow keep summing but drop the extra bytes.
// - Character errors during a message are latched for final checks.
// - At message end check error, sum, size, optional address; drop on failure.
// - Valid message with same header as last: discard, still acknowledge.
// - New header: save it, hand to sink; acknowledge only if sink took it.
// - Poll takes station number and a raw, unstuffed block check byte.
// - Poll with wrong station or any error gets no answer.
// - Held message past its retry limit goes back with error; try next.
// - Held message within its retry limit is sent again.
// - Nothing held: fetch from source, reload retries, send it.
// - Nothing held and source empty: answer end-of-transmission.
// - Poll answer layout: DLE STX, stuffed data, DLE ETX, block check.
// - Keep sent message until acknowledged or retries spent; ack frees it.
// - Negative acknowledge drains the source, returning each with error.
// - Data 0x10 travels doubled; receiver collapses, sums once.
// - Block check is two's complement of modulo-256 sum.
// - Message size must be 6 to 250 bytes inclusive.
// - Duplicate header is bytes two, three, five and six.
module hdpsl_link (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] station_number_i,
   input wire logic bcast_en_i,
   input wire logic first_chk_en_i,
   input wire logic [3:0] retry_lim_i,
   input wire logic rx_valid_i,
   input wire hdpsl_pkg::hdpsl_rx_t rx_i,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   input wire logic src_valid_i,
   input wire hdpsl_pkg::hdpsl_byte_t src_i,
   output logic src_ready_o,
   output logic src_ret_o,
   output logic src_ret_err_o,
   input wire logic sink_full_i,
   output logic sink_valid_o,
   output hdpsl_pkg::hdpsl_byte_t sink_o,
   input wire logic sink_ready_i
);
   ////////////////////////////////////////////////////////////////////////////
   // State
   hdpsl_pkg::hdpsl_st_t st_q, st_d;
   logic esc_q, esc_d, err_q, err_d, hdr_v_q, hdr_v_d, held_q, held_d;
   logic stf_q, stf_d, mid_q, mid_d, ret_q, ret_d, rerr_q, rerr_d;
   logic [7:0] sum_q, sum_d, len_q, len_d, pa_q, pa_d, hlen_q, hlen_d;
   logic [7:0] idx_q, idx_d, tsum_q, tsum_d, ctl_q, ctl_d;
   logic [31:0] hdr_q, hdr_d;
   logic [3:0] sends_q, sends_d;
   logic [2:0] ph_q, ph_d;
   logic [7:0] rbuf [hdpsl_pkg::MSG_MAX];
   logic [7:0] tbuf [hdpsl_pkg::MSG_MAX];

   ////////////////////////////////////////////////////////////////////////////
   // Destuffing: a DLE arms the escape, DLE DLE is data, DLE x is control
   wire is_dle = rx_i.data == hdpsl_pkg::CH_DLE;
   wire destuff = st_q inside {hdpsl_pkg::S_IDLE, hdpsl_pkg::S_ADDR, hdpsl_pkg::S_STX,
                               hdpsl_pkg::S_BODY, hdpsl_pkg::S_SKIP, hdpsl_pkg::S_PADDR};
   wire tok_dat = rx_valid_i && (esc_q ? is_dle : !is_dle);
   wire tok_ctl = rx_valid_i && esc_q && !is_dle;
   wire [7:0] sum_in = 8'(sum_q + rx_i.data);

   // End-of-message checks
   wire addr_hit = rx_i.data == station_number_i
                   || (bcast_en_i && rx_i.data == hdpsl_pkg::BCAST_ADDR);
   wire first_ok = !first_chk_en_i || rbuf[0] == station_number_i
                   || (bcast_en_i && rbuf[0] == hdpsl_pkg::BCAST_ADDR);
   wire size_ok = len_q >= 8'(hdpsl_pkg::MSG_MIN)
                  && len_q <= 8'(hdpsl_pkg::MSG_MAX);
   wire msg_ok = !err_q && sum_q == hdpsl_pkg::SUM_RST && size_ok && first_ok;
   wire [31:0] hdr_new = {rbuf[hdpsl_pkg::HDR_B0], rbuf[hdpsl_pkg::HDR_B1],
                          rbuf[hdpsl_pkg::HDR_B2], rbuf[hdpsl_pkg::HDR_B3]};
   wire dup = hdr_v_q && hdr_q == hdr_new;
   wire poll_ok = !err_q && !rx_i.err && pa_q == station_number_i
                  && 8'(pa_q + rx_i.data) == hdpsl_pkg::SUM_RST;
   wire spent = sends_q >= retry_lim_i;

   // Transmit byte selection feeding the FIFO
   wire [7:0] cur = tbuf[idx_q];
   wire stuff_now = cur == hdpsl_pkg::CH_DLE && !stf_q;
   logic push_v, push_rdy;
   logic [7:0] push_d;
   assign push_v = st_q == hdpsl_pkg::S_TXM || st_q == hdpsl_pkg::S_TXC;
   assign push_d = (ph_q == 3'd0 || ph_q == 3'd3) ? hdpsl_pkg::CH_DLE :
                   (st_q == hdpsl_pkg::S_TXC) ? ctl_q :
                   (ph_q == 3'd1) ? hdpsl_pkg::CH_STX :
                   (ph_q == 3'd2) ? (stuff_now ? hdpsl_pkg::CH_DLE : cur) :
                   (ph_q == 3'd4) ? hdpsl_pkg::CH_ETX : 8'(-tsum_q);

   // Local ports
   assign src_ready_o = st_q == hdpsl_pkg::S_FETCH || st_q == hdpsl_pkg::S_DRAIN;
   assign sink_valid_o = st_q == hdpsl_pkg::S_SINK;
   assign sink_o = '{data: rbuf[idx_q], last: idx_q == 8'(len_q - 8'h01)};
   assign src_ret_o = ret_q;
   assign src_ret_err_o = rerr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for receive, poll answer and source handling
   always_comb
   begin
      // A pending escape must survive idle cycles between characters
      st_d = st_q; esc_d = destuff && esc_q; err_d = err_q; sum_d = sum_q; len_d = len_q;
      pa_d = pa_q; hdr_d = hdr_q; hdr_v_d = hdr_v_q; held_d = held_q;
      hlen_d = hlen_q; sends_d = sends_q; idx_d = idx_q; ph_d = ph_q;
      stf_d = stf_q; tsum_d = tsum_q; ctl_d = ctl_q; mid_d = mid_q;
      ret_d = 1'b0; rerr_d = 1'b0;
      if (destuff && rx_valid_i)
      begin
         esc_d = !esc_q && is_dle;
      end
      if (rx_valid_i && rx_i.err && st_q inside {hdpsl_pkg::S_ADDR, hdpsl_pkg::S_STX,
          hdpsl_pkg::S_BODY, hdpsl_pkg::S_BCC, hdpsl_pkg::S_PADDR})
      begin
         err_d = 1'b1;
      end
      case (st_q)
         hdpsl_pkg::S_IDLE:
         begin
            // Only four pairs matter here; other stations' traffic falls through
            if (tok_ctl && rx_i.data == hdpsl_pkg::CH_SOH)
            begin
               sum_d = hdpsl_pkg::SUM_RST;
               len_d = hdpsl_pkg::LEN_RST;
               err_d = 1'b0;
               st_d = hdpsl_pkg::S_ADDR;
            end
            else if (tok_ctl && rx_i.data == hdpsl_pkg::CH_ENQ)
            begin
               err_d = 1'b0;
               st_d = hdpsl_pkg::S_PADDR;
            end
            else if (tok_ctl && rx_i.data == hdpsl_pkg::CH_ACK && held_q)
            begin
               held_d = 1'b0;
               ret_d = 1'b1;
            end
            else if (tok_ctl && rx_i.data == hdpsl_pkg::CH_NAK)
            begin
               held_d = 1'b0;
               ret_d = held_q;
               rerr_d = held_q;
               mid_d = 1'b0;
               st_d = hdpsl_pkg::S_DRAIN;
            end
         end
         hdpsl_pkg::S_ADDR:
         begin
            if (tok_dat && addr_hit)
            begin
               sum_d = sum_in;
               st_d = hdpsl_pkg::S_STX;
            end
            else if (tok_dat || tok_ctl)
            begin
               st_d = hdpsl_pkg::S_SKIP;
            end
         end
         hdpsl_pkg::S_STX:
         begin
            if (tok_ctl && rx_i.data == hdpsl_pkg::CH_STX)
            begin
               st_d = hdpsl_pkg::S_BODY;
            end
            else if (tok_dat || tok_ctl)
            begin
               st_d = hdpsl_pkg::S_SKIP;
            end
         end
         hdpsl_pkg::S_BODY:
         begin
            if (tok_dat)
            begin
               sum_d = sum_in;
               if (len_q <= 8'(hdpsl_pkg::MSG_MAX))
               begin
                  len_d = 8'(len_q + 8'h01); // Stops one past max to mark oversize
               end
            end
            else if (tok_ctl)
            begin
               st_d = rx_i.data == hdpsl_pkg::CH_ETX ? hdpsl_pkg::S_BCC : hdpsl_pkg::S_IDLE;
            end
         end
         hdpsl_pkg::S_BCC:
         begin
            if (rx_valid_i)
            begin
               sum_d = sum_in; // Raw byte: a stuffed-looking 0x10 is still the check
               st_d = hdpsl_pkg::S_EVAL;
            end
         end
         hdpsl_pkg::S_SKIP:
         begin
            if (tok_ctl)
            begin
               st_d = rx_i.data == hdpsl_pkg::CH_ETX ? hdpsl_pkg::S_EAT : hdpsl_pkg::S_IDLE;
            end
         end
         hdpsl_pkg::S_EAT:
         begin
            if (rx_valid_i)
            begin
               st_d = hdpsl_pkg::S_IDLE; // Swallow the trailing check byte
            end
         end
         hdpsl_pkg::S_EVAL:
         begin
            idx_d = 8'h00;
            ctl_d = hdpsl_pkg::CH_ACK;
            ph_d = 3'd0;
            if (!msg_ok)
            begin
               st_d = hdpsl_pkg::S_IDLE;
            end
            else if (dup)
            begin
               st_d = hdpsl_pkg::S_TXC;
            end
            else
            begin
               hdr_d = hdr_new;
               hdr_v_d = 1'b1;
               st_d = sink_full_i ? hdpsl_pkg::S_IDLE : hdpsl_pkg::S_SINK;
            end
         end
         hdpsl_pkg::S_SINK:
         begin
            if (sink_ready_i)
            begin
               idx_d = 8'(idx_q + 8'h01);
               if (sink_o.last)
               begin
                  st_d = hdpsl_pkg::S_TXC;
               end
            end
         end
         hdpsl_pkg::S_PADDR:
         begin
            if (tok_dat)
            begin
               pa_d = rx_i.data;
               st_d = hdpsl_pkg::S_PBCC;
            end
            else if (tok_ctl)
            begin
               st_d = hdpsl_pkg::S_IDLE;
            end
         end
         hdpsl_pkg::S_PBCC:
         begin
            idx_d = 8'h00;
            ph_d = 3'd0;
            stf_d = 1'b0;
            tsum_d = hdpsl_pkg::SUM_RST;
            ctl_d = hdpsl_pkg::CH_EOT;
            if (rx_valid_i)
            begin
               if (!poll_ok)
               begin
                  st_d = hdpsl_pkg::S_IDLE;
               end
               else if (held_q && !spent)
               begin
                  sends_d = 4'(sends_q + 4'h1);
                  st_d = hdpsl_pkg::S_TXM;
               end
               else
               begin
                  ret_d = held_q;
                  rerr_d = held_q;
                  held_d = 1'b0;
                  st_d = src_valid_i ? hdpsl_pkg::S_FETCH : hdpsl_pkg::S_TXC;
               end
            end
         end
         hdpsl_pkg::S_FETCH:
         begin
            if (src_valid_i)
            begin
               if (idx_q < 8'(hdpsl_pkg::MSG_MAX))
               begin
                  idx_d = 8'(idx_q + 8'h01);
               end
               if (src_i.last)
               begin
                  hlen_d = idx_d;
                  held_d = 1'b1;
                  sends_d = 4'h1;
                  idx_d = 8'h00;
                  st_d = hdpsl_pkg::S_TXM;
               end
            end
         end
         hdpsl_pkg::S_TXM:
         begin
            if (push_rdy)
            begin
               ph_d = 3'(ph_q + 3'd1);
               if (ph_q == 3'd2)
               begin
                  ph_d = ph_q;
                  stf_d = stuff_now;
                  if (!stuff_now)
                  begin
                     tsum_d = 8'(tsum_q + cur);
                     idx_d = 8'(idx_q + 8'h01);
                     ph_d = idx_q == 8'(hlen_q - 8'h01) ? 3'd3 : 3'd2;
                  end
               end
               else if (ph_q == 3'd5)
               begin
                  idx_d = 8'h00;
                  st_d = hdpsl_pkg::S_IDLE;
               end
            end
         end
         hdpsl_pkg::S_TXC:
         begin
            if (push_rdy)
            begin
               ph_d = 3'd1;
               st_d = ph_q == 3'd1 ? hdpsl_pkg::S_IDLE : st_q;
            end
         end
         hdpsl_pkg::S_DRAIN:
         begin
            if (src_valid_i)
            begin
               mid_d = !src_i.last;
               ret_d = src_i.last;
               rerr_d = src_i.last;
            end
            else if (!mid_q)
            begin
               st_d = hdpsl_pkg::S_IDLE;
            end
         end
         default:
         begin
            st_d = hdpsl_pkg::S_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buffers: writes past the end are dropped, the sum still runs
   always_ff @(posedge ref_clk_i)
   begin
      if (st_q == hdpsl_pkg::S_BODY && tok_dat && len_q < 8'(hdpsl_pkg::MSG_MAX))
      begin
         rbuf[len_q] <= rx_i.data;
      end
      if (st_q == hdpsl_pkg::S_FETCH && src_valid_i && idx_q < 8'(hdpsl_pkg::MSG_MAX))
      begin
         tbuf[idx_q] <= src_i.data;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= hdpsl_pkg::S_IDLE;
         {esc_q, err_q, hdr_v_q, held_q, stf_q, mid_q, ret_q, rerr_q} <= '0;
         {sum_q, len_q, pa_q, hlen_q, idx_q, tsum_q, ctl_q} <= '0;
         hdr_q <= '0;
         sends_q <= hdpsl_pkg::SENDS_RST;
         ph_q <= '0;
      end
      else
      begin
         st_q <= st_d;
         {esc_q, err_q, hdr_v_q, held_q, stf_q, mid_q, ret_q, rerr_q}
            <= {esc_d, err_d, hdr_v_d, held_d, stf_d, mid_d, ret_d, rerr_d};
         {sum_q, len_q, pa_q, hlen_q, idx_q, tsum_q, ctl_q}
            <= {sum_d, len_d, pa_d, hlen_d, idx_d, tsum_d, ctl_d};
         hdr_q <= hdr_d;
         sends_q <= sends_d;
         ph_q <= ph_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit FIFO: a stalled line stalls the transmit sequence
   hdpsl_fifo #(.W(8), .D(hdpsl_pkg::TXF_DEPTH)) u_txf (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(push_v),
      .in_data_i(push_d),
      .in_ready_o(push_rdy),
      .out_valid_o(tx_valid_o),
      .out_data_o(tx_data_o),
      .out_ready_i(tx_ready_i)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_idle_ignores_data : assert property (
      st_q == hdpsl_pkg::S_IDLE && tok_dat |=> st_q == hdpsl_pkg::S_IDLE)
      else $error("idle state left on a data code");
   a_soh_clears_sum : assert property (
      st_q == hdpsl_pkg::S_IDLE && tok_ctl && rx_i.data == hdpsl_pkg::CH_SOH
      |=> sum_q == 8'h00 && len_q == 8'h00 && !err_q)
      else $error("sum or length not cleared at start");
   a_addr_miss_skip : assert property (
      st_q == hdpsl_pkg::S_ADDR && tok_dat && !addr_hit |=> st_q == hdpsl_pkg::S_SKIP)
      else $error("mismatched address not skipped");
   a_overflow_sums : assert property (
      st_q == hdpsl_pkg::S_BODY && tok_dat && len_q > 8'(hdpsl_pkg::MSG_MAX)
      |=> $stable(len_q) && sum_q == 8'($past(sum_q) + $past(rx_i.data)))
      else $error("overflow handling wrong");
   a_dup_acked : assert property (
      st_q == hdpsl_pkg::S_EVAL && msg_ok && dup
      |=> st_q == hdpsl_pkg::S_TXC && ctl_q == hdpsl_pkg::CH_ACK && push_d == hdpsl_pkg::CH_DLE)
      else $error("duplicate not acknowledged");
   a_full_sink_silent : assert property (
      st_q == hdpsl_pkg::S_EVAL && msg_ok && !dup && sink_full_i
      |=> st_q == hdpsl_pkg::S_IDLE && hdr_q == $past(hdr_new))
      else $error("full sink not handled");
   a_bad_poll_silent : assert property (
      st_q == hdpsl_pkg::S_PBCC && rx_valid_i && !poll_ok |=> !push_v [*2])
      else $error("answer sent to rejected poll");
   a_spent_returned : assert property (
      st_q == hdpsl_pkg::S_PBCC && rx_valid_i && poll_ok && held_q && spent
      |=> src_ret_o && src_ret_err_o && !held_q)
      else $error("spent message not returned");
   a_empty_gives_eot : assert property (
      st_q == hdpsl_pkg::S_PBCC && rx_valid_i && poll_ok && !held_q && !src_valid_i
      |=> st_q == hdpsl_pkg::S_TXC && ctl_q == hdpsl_pkg::CH_EOT)
      else $error("empty source not answered with end code");
   a_ack_frees_held : assert property (
      st_q == hdpsl_pkg::S_IDLE && tok_ctl && rx_i.data == hdpsl_pkg::CH_ACK && held_q
      |=> !held_q && src_ret_o && !src_ret_err_o)
      else $error("acknowledge did not free message");

   c_msg_to_sink : cover property (st_q == hdpsl_pkg::S_SINK && sink_ready_i && sink_o.last);
   c_poll_resend : cover property (st_q == hdpsl_pkg::S_PBCC && poll_ok && held_q && !spent);
   c_poll_eot : cover property (st_q == hdpsl_pkg::S_TXC && ctl_q == hdpsl_pkg::CH_EOT);
   c_drain_ret : cover property (st_q == hdpsl_pkg::S_DRAIN && src_ret_o);

endmodule : hdpsl_link

// >>> dv/hdpsl_master.sv
module hdpsl_master (
   input wire logic ref_clk_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o,
   output logic rx_valid_o,
   output hdpsl_pkg::hdpsl_rx_t rx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_q[$];

   initial
   begin
      tx_ready_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_o = '0;
   end

   // Collects slave bytes; random stalls let the slave's FIFO fill up
   always @(posedge ref_clk_i)
   begin
      if (tx_valid_i && tx_ready_o)
         got_q.push_back(tx_data_i);
      tx_ready_o <= ($urandom % 4) != 0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One character a cycle with random idle gaps, stuffing and check byte done by the caller
   // Idle line shows junk, so a stale value is never mistaken for data
   task automatic send(input logic [7:0] f[$], input logic bad);
      foreach (f[i])
      begin
         @(posedge ref_clk_i);
         rx_valid_o <= 1'b1;
         rx_o <= '{data: f[i], err: bad && i == 2};
         if ($urandom % 4 == 0)
         begin
            // Idle gap between characters, as a real serial line has
            @(posedge ref_clk_i);
            rx_valid_o <= 1'b0;
            rx_o <= '{data: ~f[i], err: 1'b0};
         end
      end
      @(posedge ref_clk_i);
      rx_valid_o <= 1'b0;
      rx_o <= '{data: ~f[f.size()-1], err: 1'b0};
   endtask : send
endmodule : hdpsl_master

// >>> dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef logic [7:0] hdpsl_bq_t[$];
   localparam logic [7:0] STATION_NUMBER = 8'h20;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sink_full_i = 1'b0;
   logic sink_ready_i = 1'b0;
   logic src_valid_i = 1'b0;
   logic rx_valid_i, tx_valid_o, tx_ready_i, src_ready_o, src_ret_o, src_ret_err_o, sink_valid_o;
   logic [7:0] tx_data_o;
   hdpsl_pkg::hdpsl_rx_t rx_i;
   hdpsl_pkg::hdpsl_byte_t src_i = '0;
   hdpsl_pkg::hdpsl_byte_t sink_o;
   hdpsl_pkg::hdpsl_byte_t src_q[$];
   hdpsl_bq_t sink_got, d, m, ack_q, eot_q, none_q;
   int num_errors = 0;
   int n_compared = 0;
   int n_ok = 0;
   int n_err = 0;
   int n;

   always #5 ref_clk_i = ~ref_clk_i;

   // Static setup: retry limit two, broadcast accepted, first byte checked
   hdpsl_link dut_u (.ref_clk_i, .rst_n_i, .station_number_i(STATION_NUMBER), .bcast_en_i(1'b1),
      .first_chk_en_i(1'b1), .retry_lim_i(4'h2), .rx_valid_i, .rx_i, .tx_valid_o, .tx_data_o,
      .tx_ready_i, .src_valid_i, .src_i, .src_ready_o, .src_ret_o, .src_ret_err_o,
      .sink_full_i, .sink_valid_o, .sink_o, .sink_ready_i);
   hdpsl_master master_u (.ref_clk_i, .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_o(rx_i));

   // Source queue, stalling sink and return counters
   always @(posedge ref_clk_i)
   begin
      if (src_valid_i && src_ready_o)
         void'(src_q.pop_front());
      src_valid_i <= src_q.size() != 0;
      src_i <= (src_q.size() != 0) ? src_q[0] : ~src_i;
      if (sink_valid_o && sink_ready_i)
         sink_got.push_back(sink_o.data);
      sink_ready_i <= ($urandom % 3) != 0;
      if (src_ret_o && src_ret_err_o)
         n_err++;
      if (src_ret_o && !src_ret_err_o)
         n_ok++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict();
      $display("errors %0d, comparisons %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   // One cycle of a bounded wait; running out ends the run as a failure
   task automatic tick(int k);
      if (k == 1000)
      begin
         num_errors++;
         print_verdict();
      end
      else
      begin
         @(posedge ref_clk_i);
      end
   endtask : tick

   // Master packet, or slave answer when slv: stuffed data, check byte raw
   function automatic hdpsl_bq_t frame(hdpsl_bq_t x, logic [7:0] adr, logic slv);
      hdpsl_bq_t f;
      logic [7:0] s;
      s = slv ? 8'h00 : adr;
      f = {hdpsl_pkg::CH_DLE, hdpsl_pkg::CH_STX};
      if (!slv)
         f = {hdpsl_pkg::CH_DLE, hdpsl_pkg::CH_SOH, adr, f};
      foreach (x[i])
      begin
         s += x[i];
         f.push_back(x[i]);
         if (x[i] == hdpsl_pkg::CH_DLE)
            f.push_back(x[i]);
      end
      return {f, hdpsl_pkg::CH_DLE, hdpsl_pkg::CH_ETX, 8'(-s)};
   endfunction : frame

   // Random body; byte 3 is always the escape value, byte 1 varies the header
   function automatic hdpsl_bq_t rnd(int len, logic [7:0] t);
      hdpsl_bq_t x;
      repeat (len) x.push_back(8'($urandom));
      x[3] = hdpsl_pkg::CH_DLE;
      x[1] = t;
      x[0] = STATION_NUMBER; // First byte names the station
      return x;
   endfunction : rnd

   task automatic expect_tx(hdpsl_bq_t e);
      for (n = 0; master_u.got_q.size() < e.size(); n++) tick(n);
      repeat (60) @(posedge ref_clk_i); // Room for a stray extra byte to show
      check("tx count", master_u.got_q.size(), e.size());
      foreach (e[i]) check("tx byte", master_u.got_q[i], e[i]);
      master_u.got_q.delete();
   endtask : expect_tx

   task automatic wait_ret(int ok, int err);
      for (n = 0; n_ok < ok || n_err < err; n++) tick(n);
      repeat (5) @(posedge ref_clk_i);
      check("returns ok", n_ok, ok);
      check("returns err", n_err, err);
   endtask : wait_ret

   task automatic load(hdpsl_bq_t x);
      foreach (x[i]) src_q.push_back('{data: x[i], last: i == x.size() - 1});
   endtask : load

   task automatic poll(logic [7:0] a, logic [7:0] c, logic bad);
      master_u.send({hdpsl_pkg::CH_DLE, hdpsl_pkg::CH_ENQ, a, c}, bad);
   endtask : poll

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'hD180DD30));
      ack_q = {hdpsl_pkg::CH_DLE, hdpsl_pkg::CH_ACK};
      eot_q = {hdpsl_pkg::CH_DLE, hdpsl_pkg::CH_EOT};
      repeat (2) @(posedge ref_clk_i);
      #1 check("reset outs", {tx_valid_o, src_ready_o, src_ret_o, sink_valid_o}, 4'h0);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      // Stray codes, then bad polls, draw no answer; a good poll on empty source does
      master_u.send({8'h41, hdpsl_pkg::CH_DLE, hdpsl_pkg::CH_ETX, 8'h7E, ack_q}, 1'b0);
      expect_tx(none_q);
      poll(STATION_NUMBER + 8'h01, -(STATION_NUMBER + 8'h01), 1'b0);
      expect_tx(none_q);
      poll(STATION_NUMBER, STATION_NUMBER, 1'b0);
      expect_tx(none_q);
      poll(STATION_NUMBER, -STATION_NUMBER, 1'b1);
      expect_tx(none_q);
      poll(STATION_NUMBER, -STATION_NUMBER, 1'b0);
      expect_tx(eot_q);
      // Good, repeat, short, bad check, foreign, long, broadcast, sink full, char error,
      // wrong first byte
      for (int k = 0; k < 10; k++)
      begin
         if (k != 1)
            d = rnd(k == 2 ? 5 : k == 5 ? 252 : k == 6 ? 250 : 6, 8'(k));
         if (k == 9)
            d[0] = 8'h00;
         m = frame(d, k == 4 ? STATION_NUMBER + 8'h01 : k == 6 ? 8'hFF : STATION_NUMBER, 1'b0);
         if (k == 3)
            m[m.size()-1] += 8'h01;
         sink_full_i <= k == 7;
         master_u.send(m, k == 8);
         expect_tx(k < 2 || k == 6 ? ack_q : none_q);
         check("sink count", sink_got.size(), k == 0 || k == 6 ? d.size() : 0);
         foreach (sink_got[i]) check("sink byte", sink_got[i], d[i]);
         sink_got.delete();
      end
      // Master polls one station until it answers end-of-transmission
      d = rnd(6, 8'hA0);
      m = rnd(7, 8'hB0);
      load(d);
      load(m);
      poll(STATION_NUMBER, -STATION_NUMBER, 1'b0);
      expect_tx(frame(d, 8'h00, 1'b1));
      poll(STATION_NUMBER, -STATION_NUMBER, 1'b0);
      expect_tx(frame(d, 8'h00, 1'b1));
      poll(STATION_NUMBER, -STATION_NUMBER, 1'b0);
      expect_tx(frame(m, 8'h00, 1'b1));
      wait_ret(0, 1);
      master_u.send(ack_q, 1'b0);
      wait_ret(1, 1);
      poll(STATION_NUMBER, -STATION_NUMBER, 1'b0);
      expect_tx(eot_q);
      // Negative acknowledge empties a loaded source
      load(rnd(6, 8'h01));
      load(rnd(9, 8'h02));
      master_u.send({hdpsl_pkg::CH_DLE, hdpsl_pkg::CH_NAK}, 1'b0);
      wait_ret(1, 3);
      check("source left", src_q.size(), 0);
      print_verdict();
   end
endmodule : testbench
